// ---- hw/chiller_status_readout.v ----
// Purpose: read-only monitoring registers of a process chiller
// Assumes: the serial protocol engine presents a register index and a read strobe
// Notes: value inputs are pins from the controller and are synchronised first
`timescale 1ns/10ps
`default_nettype none
`include "chiller_readout_defines.vh"
module chiller_status_readout (
    input  wire        ref_clk,          // 250 MHz clock
    input  wire        reset,            // async reset, active high
    input  wire [15:0] regIndex,         // register index from protocol engine
    input  wire        readStrobe,       // one-cycle read request
    output reg  [15:0] readData,         // read data, registered
    output reg         readValid,        // read data valid pulse
    output reg         readError,        // index out of range pulse
    input  wire [15:0] tempCelsius,      // measured temperature, 0.1 C
    input  wire [15:0] tempFahrenheit,   // measured temperature, 0.1 F
    input  wire [15:0] tempOffset,       // offset in selected unit, 0.1 deg
    input  wire        offsetEnable,     // offset function configured
    input  wire [15:0] pressMpa,         // pressure, 0.01 MPa
    input  wire [15:0] pressPsi,         // pressure, 1 PSI
    input  wire [15:0] resistValue,      // resistivity, 0.1 Mohm cm
    input  wire        resistEnable,     // resistivity sensor enabled
    input  wire        runActive,        // circulation or pump-only running
    input  wire        stopAlarm,        // operation-stop alarm active
    input  wire        contAlarm,        // operation-continue alarm active
    input  wire        pressUnitPsi,     // 1 selects PSI
    input  wire        serialRemote,     // serial remote mode
    input  wire        tempReady,        // temperature ready condition
    input  wire        tempUnitF,        // 1 selects Fahrenheit
    input  wire        runTimerSet,      // run timer configured
    input  wire        stopTimerSet,     // stop timer configured
    input  wire        powerRestartSet,  // restart after power failure set
    input  wire        antiFreezeSet,    // anti-freezing configured
    input  wire        autoFilling,      // filling in progress
    output wire [15:0] unit_status_word  // status word, registered
);
    // ************************************************************
    // input synchronisers
    // ************************************************************
    localparam NBUS = 16 * 7;
    localparam NBIT = 15;
    wire [NBUS-1:0] busIn = {tempCelsius, tempFahrenheit, tempOffset, pressMpa,
                             pressPsi, resistValue, 16'h0000};
    wire [NBIT-1:0] bitIn = {offsetEnable, resistEnable, runActive, stopAlarm,
                             contAlarm, pressUnitPsi, serialRemote, tempReady,
                             tempUnitF, runTimerSet, stopTimerSet, powerRestartSet,
                             antiFreezeSet, autoFilling, 1'b0};
    reg  [NBUS-1:0] busMeta_reg;
    reg  [NBUS-1:0] busSync_reg;
    reg  [NBIT-1:0] bitMeta_reg;
    reg  [NBIT-1:0] bitSync_reg;

    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            busMeta_reg <= {NBUS{1'b0}};
            busSync_reg <= {NBUS{1'b0}};
            bitMeta_reg <= {NBIT{1'b0}};
            bitSync_reg <= {NBIT{1'b0}};
        end else begin
            busMeta_reg <= busIn;
            busSync_reg <= busMeta_reg;
            bitMeta_reg <= bitIn;
            bitSync_reg <= bitMeta_reg;
        end
    end

    wire [15:0] sCel     = busSync_reg[111:96];
    wire [15:0] sFah     = busSync_reg[95:80];
    wire [15:0] sOff     = busSync_reg[79:64];
    wire [15:0] sMpa     = busSync_reg[63:48];
    wire [15:0] sPsi     = busSync_reg[47:32];
    wire [15:0] sRes     = busSync_reg[31:16];
    wire        sOffEn   = bitSync_reg[14];
    wire        sResEn   = bitSync_reg[13];
    wire        sRun     = bitSync_reg[12];
    wire        sStopAl  = bitSync_reg[11];
    wire        sContAl  = bitSync_reg[10];
    wire        sPsiSel  = bitSync_reg[9];
    wire        sRemote  = bitSync_reg[8];
    wire        sReady   = bitSync_reg[7];
    wire        sFahSel  = bitSync_reg[6];
    wire        sRunTmr  = bitSync_reg[5];
    wire        sStopTmr = bitSync_reg[4];
    wire        sPwrRst  = bitSync_reg[3];
    wire        sAntiFr  = bitSync_reg[2];
    wire        sFilling = bitSync_reg[1];

    // ************************************************************
    // value selection and range limiting
    // ************************************************************
    wire [15:0] tempUnitVal = sFahSel ? sFah : sCel;
    // sum wraps at 16 bits before clamping
    wire [16:0] tempSum     = {1'b0, tempUnitVal} + {1'b0, sOff};
    wire [15:0] tempAdj     = sOffEn ? tempSum[15:0] : tempUnitVal;
    wire [15:0] tempLo      = sFahSel ? `TEMP_F_MIN : `TEMP_C_MIN;
    wire [15:0] tempHi      = sFahSel ? `TEMP_F_MAX : `TEMP_C_MAX;
    wire [15:0] pressUnitVal = sPsiSel ? sPsi : sMpa;
    wire [15:0] pressHi      = sPsiSel ? `PRESS_PSI_MAX : `PRESS_MPA_MAX;
    wire [15:0] resGated     = sResEn ? sRes : 16'h0000;
    wire [15:0] tempClamped;
    wire [15:0] pressClamped;
    wire [15:0] resClamped;

    value_clamp #(.SIGNED_CMP(1)) tempClamp (
        .rawValue   (tempAdj),
        .lowLimit   (tempLo),
        .highLimit  (tempHi),
        .clampValue (tempClamped)
    );
    value_clamp #(.SIGNED_CMP(0)) pressClamp (
        .rawValue   (pressUnitVal),
        .lowLimit   (16'h0000),
        .highLimit  (pressHi),
        .clampValue (pressClamped)
    );
    value_clamp #(.SIGNED_CMP(0)) resClamp (
        .rawValue   (resGated),
        .lowLimit   (16'h0000),
        .highLimit  (`RESIST_MAX),
        .clampValue (resClamped)
    );

    // ************************************************************
    // register images
    // ************************************************************
    reg  [15:0] tempVal_reg;
    reg  [15:0] pressVal_reg;
    reg  [15:0] resVal_reg;
    reg  [15:0] status_reg;
    reg  [15:0] status_next;

    always @* begin
        status_next                    = `STATUS_RESET;
        status_next[`ST_RUN]           = sRun;
        status_next[`ST_STOP_ALARM]    = sStopAl;
        status_next[`ST_CONT_ALARM]    = sContAl;
        status_next[`ST_PRESS_UNIT]    = sPsiSel;
        status_next[`ST_REMOTE]        = sRemote;
        status_next[`ST_TEMP_READY]    = sReady;
        status_next[`ST_TEMP_UNIT]     = sFahSel;
        status_next[`ST_RUN_TIMER]     = sRunTmr;
        status_next[`ST_STOP_TIMER]    = sStopTmr;
        status_next[`ST_POWER_RESTART] = sPwrRst;
        status_next[`ST_ANTI_FREEZE]   = sAntiFr;
        // filling follows its input regardless of option fit
        status_next[`ST_AUTO_FILL]     = sFilling;
    end

    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            tempVal_reg  <= 16'h0000;
            pressVal_reg <= 16'h0000;
            resVal_reg   <= 16'h0000;
            status_reg   <= `STATUS_RESET;
        end else begin
            tempVal_reg  <= tempClamped;
            pressVal_reg <= pressClamped;
            resVal_reg   <= resClamped;
            status_reg   <= status_next;
        end
    end

    assign unit_status_word = status_reg;

    // ************************************************************
    // read port
    // ************************************************************
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            readData  <= 16'h0000;
            readValid <= 1'b0;
            readError <= 1'b0;
        end else begin
            readValid <= 1'b0;
            readError <= 1'b0;
            if (readStrobe) begin
                case (regIndex)
                    `REG_DISCHARGE_TEMP: begin
                        readData  <= tempVal_reg;
                        readValid <= 1'b1;
                    end
                    `REG_RESERVED_1: begin
                        readData  <= 16'h0000;
                        readValid <= 1'b1;
                    end
                    `REG_DISCHARGE_PRESS: begin
                        readData  <= pressVal_reg;
                        readValid <= 1'b1;
                    end
                    `REG_RESISTIVITY: begin
                        readData  <= resVal_reg;
                        readValid <= 1'b1;
                    end
                    `REG_UNIT_STATUS: begin
                        readData  <= status_reg;
                        readValid <= 1'b1;
                    end
                    default: begin
                        readData  <= 16'h0000;
                        readError <= 1'b1;
                    end
                endcase
            end
        end
    end
endmodule // chiller_status_readout
`default_nettype wire

// ---- inc/chiller_readout_defines.vh ----
// Purpose: constants for the chiller status readout block
// Assumes: 16-bit register words, register index addressing
// Notes: register indices are those of the readout map
`ifndef CHILLER_READOUT_DEFINES_VH
`define CHILLER_READOUT_DEFINES_VH

`define REG_DISCHARGE_TEMP   16'h0000
`define REG_RESERVED_1       16'h0001
`define REG_DISCHARGE_PRESS  16'h0002
`define REG_RESISTIVITY      16'h0003
`define REG_UNIT_STATUS      16'h0004

`define ST_RUN               0
`define ST_STOP_ALARM        1
`define ST_CONT_ALARM        2
`define ST_PRESS_UNIT        4
`define ST_REMOTE            5
`define ST_TEMP_READY        9
`define ST_TEMP_UNIT         10
`define ST_RUN_TIMER         11
`define ST_STOP_TIMER        12
`define ST_POWER_RESTART     13
`define ST_ANTI_FREEZE       14
`define ST_AUTO_FILL         15

`define STATUS_RESET         16'h0000
`define PRESS_MPA_MAX        16'h012C
`define PRESS_PSI_MAX        16'h01B3
`define TEMP_C_MIN           16'hFBB4
`define TEMP_C_MAX           16'h05DC
`define TEMP_F_MIN           16'hF984
`define TEMP_F_MAX           16'h0BCC
`define RESIST_MAX           16'h002D

`endif

// ---- hw/value_clamp.v ----
// Purpose: clamp a signed or unsigned 16-bit value into a range
// Assumes: lowLimit is not above highLimit
// Notes: combinational
`timescale 1ns/10ps
`default_nettype none
module value_clamp #(
    parameter SIGNED_CMP = 0
) (
    input  wire [15:0] rawValue,   // value to clamp
    input  wire [15:0] lowLimit,   // lowest legal code
    input  wire [15:0] highLimit,  // highest legal code
    output reg  [15:0] clampValue  // clamped code
);
    always @* begin
        clampValue = rawValue;
        if (SIGNED_CMP != 0) begin
            if ($signed(rawValue) < $signed(lowLimit)) begin
                clampValue = lowLimit;
            end else if ($signed(rawValue) > $signed(highLimit)) begin
                clampValue = highLimit;
            end
        end else begin
            if (rawValue < lowLimit) begin
                clampValue = lowLimit;
            end else if (rawValue > highLimit) begin
                clampValue = highLimit;
            end
        end
    end
endmodule // value_clamp
`default_nettype wire

// ---- bench/readout_checker.sv ----
// Purpose: assertion checker for the chiller status readout
// Assumes: status word lags its inputs by three clock edges
// Notes: bound to the top module by name
`timescale 1ns/10ps
`default_nettype none
module readout_checker (
    input wire logic        ref_clk,         // clock
    input wire logic        reset,           // async reset
    input wire logic [15:0] regIndex,        // read index
    input wire logic        readStrobe,      // read request
    input wire logic [15:0] readData,        // read data
    input wire logic        readValid,       // read done
    input wire logic        readError,       // bad index
    input wire logic        runActive,       // bit 0 source
    input wire logic        stopAlarm,       // bit 1 source
    input wire logic        contAlarm,       // bit 2 source
    input wire logic        pressUnitPsi,    // bit 4 source
    input wire logic        serialRemote,    // bit 5 source
    input wire logic        autoFilling,     // bit 15 source
    input wire logic [15:0] unit_status_word // status word
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    logic [1:0] upCnt_reg;
    wire        upOk = (upCnt_reg == 2'h3);
    // pipeline holds reset zeros for three edges after release
    always @(posedge ref_clk or posedge reset) begin
        if (reset) upCnt_reg <= 2'h0;
        else if (!upOk) upCnt_reg <= upCnt_reg + 2'h1;
    end
    a_run_bit: assert property (upOk |-> unit_status_word[0] == $past(runActive, 3))
        else $error("run bit wrong");
    a_stop_alarm: assert property (upOk |-> unit_status_word[1] == $past(stopAlarm, 3))
        else $error("stop alarm bit wrong");
    a_cont_alarm: assert property (upOk |-> unit_status_word[2] == $past(contAlarm, 3))
        else $error("continue alarm bit wrong");
    a_press_unit: assert property (upOk |-> unit_status_word[4] == $past(pressUnitPsi, 3))
        else $error("pressure unit bit wrong");
    a_remote_bit: assert property (upOk |-> unit_status_word[5] == $past(serialRemote, 3))
        else $error("remote bit wrong");
    a_fill_bit: assert property (upOk |-> unit_status_word[15] == $past(autoFilling, 3))
        else $error("filling bit wrong");
    a_unused_zero: assert property (unit_status_word[8:6] == 3'h0 && !unit_status_word[3])
        else $error("unused status bit set");
    a_status_read: assert property (readStrobe && regIndex == 16'h0004 |=>
        readValid && readData == $past(unit_status_word)) else $error("status read wrong");
    a_range_error: assert property (readStrobe && regIndex > 16'h0004 |=>
        readError && !readValid && readData == 16'h0000) else $error("bad index not refused");
    a_answer_cause: assert property ((readValid || readError) |-> $past(readStrobe))
        else $error("answer without request");
    c_status_read: cover property (readStrobe && regIndex == 16'h0004);
    c_range_error: cover property (readError);
    c_fill_seen: cover property (unit_status_word[15]);
endmodule // readout_checker
bind chiller_status_readout readout_checker u_chk (.ref_clk, .reset, .regIndex, .readStrobe,
    .readData, .readValid, .readError, .runActive, .stopAlarm, .contAlarm, .pressUnitPsi,
    .serialRemote, .autoFilling, .unit_status_word);
`default_nettype wire

// ---- bench/readout_host.sv ----
// Purpose: host side that reads registers one word at a time
// Assumes: answer comes one edge after the request is taken
// Notes: index line shows the inverse of the last index while idle
`timescale 1ns/10ps
`default_nettype none
module readout_host (
    input  wire logic        ref_clk,    // clock
    output var  logic [15:0] regIndex,   // read index
    output var  logic        readStrobe, // read request
    input  wire logic [15:0] readData,   // read data
    input  wire logic        readValid,  // read done
    input  wire logic        readError   // bad index
);
    initial begin
        regIndex = 16'hFFFF;
        readStrobe = 1'h0;
    end
    task automatic do_read(input logic [15:0] idx, output logic [15:0] data, output logic err);
        @(posedge ref_clk);
        readStrobe <= 1'h1;
        regIndex <= idx;
        @(posedge ref_clk);
        readStrobe <= 1'h0;
        regIndex <= ~idx;
        @(posedge ref_clk);
        data = readData;
        err = readError | ~readValid;
    endtask
endmodule // readout_host
`default_nettype wire

// ---- bench/chiller_status_readout_tb_top.sv ----
// Purpose: self-checking bench for the chiller status readout
// Assumes: inputs need three edges to reach the register images
// Notes: flag rows first, then value and refusal cases
`timescale 1ns/10ps
`default_nettype none
module chiller_status_readout_tb_top;
    logic        ref_clk, reset, offsetEnable, resistEnable, readStrobe, readValid, readError, err;
    logic [11:0] flags;
    logic [15:0] tempC, tempF, tempOff, pMpa, pPsi, resist, regIndex, readData, statusWord, got;
    int          n_fail = 0;
    int          n_checks = 0;
    logic [15:0] expStat [0:11] = '{16'h0001, 16'h0002, 16'h0004, 16'h0010, 16'h0020, 16'h0200,
        16'h0400, 16'h0800, 16'h1000, 16'h2000, 16'h4000, 16'h8000};
    chiller_status_readout u_dut (.ref_clk, .reset, .regIndex, .readStrobe, .readData,
        .readValid, .readError, .tempCelsius(tempC), .tempFahrenheit(tempF), .tempOffset(tempOff),
        .offsetEnable, .pressMpa(pMpa), .pressPsi(pPsi), .resistValue(resist), .resistEnable,
        .runActive(flags[0]), .stopAlarm(flags[1]), .contAlarm(flags[2]),
        .pressUnitPsi(flags[3]), .serialRemote(flags[4]), .tempReady(flags[5]),
        .tempUnitF(flags[6]), .runTimerSet(flags[7]), .stopTimerSet(flags[8]),
        .powerRestartSet(flags[9]), .antiFreezeSet(flags[10]), .autoFilling(flags[11]),
        .unit_status_word(statusWord));
    readout_host u_host (.ref_clk, .regIndex, .readStrobe, .readData, .readValid, .readError);
    initial begin
        ref_clk = 1'h0;
        forever #2 ref_clk = ~ref_clk;
    end
    task cmp(input logic [15:0] g, input logic [15:0] e);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // settle, read one word, compare data and refusal flag
    task rd(input logic [15:0] idx, input logic [15:0] e);
        repeat (4) @(posedge ref_clk);
        u_host.do_read(idx, got, err);
        cmp(got, e);
        cmp({15'h0000, err}, {15'h0000, idx > 16'h0004});
    endtask
    task stop_test;
        $display("checks=%0d failures=%0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge ref_clk);
        n_fail++;
        stop_test;
    end
    initial begin
        reset = 1'h1;
        flags = 12'h000;
        offsetEnable = 1'h0;
        resistEnable = 1'h0;
        tempC = 16'h00FA;
        tempF = 16'hF984;
        tempOff = 16'h000A;
        pMpa = 16'h012C;
        pPsi = 16'h01B3;
        resist = 16'h0020;
        repeat (10) @(posedge ref_clk);
        reset <= 1'h0;
        for (int i = 0; i < 12; i++) begin
            @(posedge ref_clk) flags <= 12'h001 << i;
            rd(16'h0004, expStat[i]);
            cmp(statusWord, expStat[i]);
        end
        @(posedge ref_clk) flags <= 12'hFFF;
        rd(16'h0004, 16'hFE37);
        @(posedge ref_clk) flags <= 12'h000;
        rd(16'h0003, 16'h0000);
        @(posedge ref_clk) resistEnable <= 1'h1;
        rd(16'h0003, 16'h0020);
        rd(16'h0002, 16'h012C);
        @(posedge ref_clk) flags <= 12'h008;
        rd(16'h0002, 16'h01B3);
        rd(16'h0000, 16'h00FA);
        @(posedge ref_clk) flags <= 12'h040;
        rd(16'h0000, 16'hF984);
        @(posedge ref_clk) offsetEnable <= 1'h1;
        rd(16'h0000, 16'hF98E);
        @(posedge ref_clk) flags <= 12'h000;
        rd(16'h0000, 16'h0104);
        rd(16'h0001, 16'h0000);
        rd(16'h0005, 16'h0000);
        rd(16'hFFFF, 16'h0000);
        // mid-run reset clears the status word, then it refills
        @(posedge ref_clk) flags <= 12'hFFF;
        repeat (4) @(posedge ref_clk);
        reset <= 1'h1;
        @(negedge ref_clk);
        cmp(statusWord, 16'h0000);
        @(posedge ref_clk) reset <= 1'h0;
        rd(16'h0004, 16'hFE37);
        cmp(statusWord, 16'hFE37);
        stop_test;
    end
endmodule // chiller_status_readout_tb_top
`default_nettype wire
